// file: src/pmw_power_mode_wake.v
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "pmw_consts.vh"

module pmw_power_mode_wake (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  // CPU side events
  input  wire        haltExec,
  input  wire        clearWdtExec,
  input  wire        stackFull,
  input  wire [7:0]  irqRequest,
  input  wire [7:0]  irqEnable,
  input  wire [7:0]  portAPins,
  // Configuration and sub clock
  input  wire        extHighOsc,
  input  wire        extLowOsc,
  input  wire        subTick,
  // Clock and power control
  output reg  [1:0]  sysClkSource,
  output reg  [2:0]  sysClkDivSel,
  output reg         sysClkRun,
  output reg         timebaseClkRun,
  output reg         subClkRun,
  output reg         highOscRun,
  output reg         cpuHalted,
  output reg         ioHold,
  output reg         pcStackReset,
  output reg         irqService,
  output reg         wdtResetReq
);

  // ****************************************************
  // States
  // ****************************************************
  localparam [6:0] ST_NORMAL = 7'h01;
  localparam [6:0] ST_DIV    = 7'h02;
  localparam [6:0] ST_LOW    = 7'h04;
  localparam [6:0] ST_SLEEP  = 7'h08;
  localparam [6:0] ST_IDLE_CLOCK_OFF  = 7'h10;
  localparam [6:0] ST_IDLE_CLOCK_ON  = 7'h20;
  localparam [6:0] ST_START  = 7'h40;

  // ****************************************************
  // Functions
  // ****************************************************
  function [6:0] runModeFor;
    input       highSel;
    input [2:0] divSel;
    begin
      if (highSel)
        runModeFor = ST_NORMAL;
      else if (divSel[2:1] == 2'h0)
        runModeFor = ST_LOW;
      else
        runModeFor = ST_DIV;
    end
  endfunction

  function [17:0] wdtTerminal;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    wdtTerminal = 18'h000FF;
        3'h1:    wdtTerminal = 18'h003FF;
        3'h2:    wdtTerminal = 18'h00FFF;
        3'h3:    wdtTerminal = 18'h03FFF;
        3'h4:    wdtTerminal = 18'h07FFF;
        3'h5:    wdtTerminal = 18'h0FFFF;
        3'h6:    wdtTerminal = 18'h1FFFF;
        default: wdtTerminal = 18'h3FFFF;
      endcase
    end
  endfunction

  // ****************************************************
  // Registers and state
  // ****************************************************
  reg  [2:0]  divSel;
  reg         fastWake;
  reg         idleOnHalt;
  reg         highSel;
  reg         sysIdle;
  reg  [2:0]  wdtPeriod;
  reg  [7:0]  portAWakeEn;
  reg         poweredDown;
  reg         wdtTimeout;
  reg         lowReady;
  reg         highReady;
  reg  [6:0]  state;
  reg  [6:0]  next_state;
  reg         runOnLow;
  reg         next_runOnLow;
  reg  [7:0]  irqMaskAtHalt;
  reg  [7:0]  portAPrev;
  reg  [17:0] wdtCount;
  reg  [7:0]  sstCount;
  reg  [7:0]  sstTarget;
  reg         sstBusy;
  reg         sstForLow;
  reg         startHigh;
  reg         stopHigh;
  reg         wakeWdt;
  reg         wakeIrq;
  reg         wdtClear;

  // AHB data phase capture
  reg         dpWrite;
  reg  [7:0]  dpAddr;

  wire [6:0] targetRun  = runModeFor(highSel, divSel);
  wire       downState  = |(state & (ST_SLEEP | ST_IDLE_CLOCK_OFF | ST_IDLE_CLOCK_ON));
  wire       portAEdge  = |(portAPrev & ~portAPins & portAWakeEn);
  wire       irqWakeSrc = |(irqRequest & ~irqMaskAtHalt);
  wire       wdtOverflow = subTick && (wdtCount == wdtTerminal(wdtPeriod));
  wire       haltTaken  = haltExec && (state == ST_NORMAL ||
                          state == ST_DIV || state == ST_LOW);
  wire       anyWake    = downState && (portAEdge || irqWakeSrc ||
                          wdtOverflow);
  wire       irqReady   = |(irqRequest & ~irqMaskAtHalt & irqEnable);
  wire       apValid    = hsel && hready && htrans[1];
  wire [7:0] apAddr     = haddr[7:0];

  // ****************************************************
  // Mode sequencing
  // ****************************************************
  always @* begin
    next_state    = state;
    next_runOnLow = runOnLow;
    startHigh     = 1'b0;
    stopHigh      = 1'b0;
    wakeWdt       = 1'b0;
    wakeIrq       = 1'b0;
    case (state)
      ST_NORMAL, ST_DIV, ST_LOW: begin
        if (haltTaken) begin
          if (!idleOnHalt)
            next_state = ST_SLEEP;
          else if (sysIdle)
            next_state = ST_IDLE_CLOCK_ON;
          else
            next_state = ST_IDLE_CLOCK_OFF;
          if (!idleOnHalt || !sysIdle)
            stopHigh = 1'b1;
        end else if (targetRun == ST_LOW) begin
          if (lowReady && state != ST_LOW) begin
            next_state = ST_LOW;
            stopHigh   = 1'b1;
          end
        end else if (state == ST_LOW) begin
          next_state    = ST_START;
          next_runOnLow = 1'b1;
          startHigh     = 1'b1;
        end else begin
          next_state = targetRun;
        end
      end
      ST_SLEEP, ST_IDLE_CLOCK_OFF, ST_IDLE_CLOCK_ON: begin
        if (anyWake) begin
          wakeWdt = wdtOverflow;
          wakeIrq = irqReady && !stackFull;
          if (targetRun == ST_LOW) begin
            next_state = ST_LOW;
          end else if (highReady) begin
            next_state = targetRun;
          end else begin
            next_state    = ST_START;
            startHigh     = 1'b1;
            next_runOnLow = (state == ST_SLEEP) && fastWake &&
                            extHighOsc;
          end
        end
      end
      ST_START: begin
        if (highReady) begin
          next_state    = targetRun;
          next_runOnLow = 1'b0;
        end
      end
      default: begin
        next_state = ST_START;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state         <= ST_START;
      runOnLow      <= 1'b0;
      irqMaskAtHalt <= 8'h00;
      portAPrev     <= 8'h00;
    end else begin
      state     <= next_state;
      runOnLow  <= next_runOnLow;
      portAPrev <= portAPins;
      if (haltTaken)
        irqMaskAtHalt <= irqRequest;
      else if (!downState)
        irqMaskAtHalt <= 8'h00;
    end
  end

  // ****************************************************
  // Shared start-up counter
  // ****************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sstCount  <= 8'h00;
      sstTarget <= 8'h00;
      sstBusy   <= 1'b0;
      sstForLow <= 1'b1;
      lowReady  <= 1'b0;
      highReady <= 1'b0;
    end else begin
      if (stopHigh)
        highReady <= 1'b0;
      if (!sstBusy && !lowReady) begin
        sstBusy   <= 1'b1;
        sstForLow <= 1'b1;
        sstCount  <= 8'h00;
        sstTarget <= extLowOsc ? `PMW_SST_EXT_LOW : `PMW_SST_INT_LOW;
      end else if (startHigh || (!sstBusy && lowReady && !highReady &&
                   state == ST_START)) begin
        sstBusy   <= 1'b1;
        sstForLow <= 1'b0;
        sstCount  <= 8'h00;
        sstTarget <= extHighOsc ? `PMW_SST_EXT_HIGH :
                                  `PMW_SST_INT_HIGH;
        highReady <= 1'b0;
      end else if (sstBusy) begin
        if (sstCount == sstTarget - 8'h01) begin
          sstBusy <= 1'b0;
          if (sstForLow)
            lowReady <= 1'b1;
          else
            highReady <= 1'b1;
        end else begin
          sstCount <= sstCount + 8'h01;
        end
      end
    end
  end

  // ****************************************************
  // Watchdog and status flags
  // ****************************************************
  always @* begin
    wdtClear = haltTaken || clearWdtExec || wdtOverflow;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdtCount    <= 18'h00000;
      poweredDown <= 1'b0;
      wdtTimeout  <= 1'b0;
    end else begin
      if (wdtClear)
        wdtCount <= 18'h00000;
      else if (subTick)
        wdtCount <= wdtCount + 18'h00001;
      if (haltTaken)
        poweredDown <= 1'b1;
      else if (clearWdtExec)
        poweredDown <= 1'b0;
      if (wdtOverflow)
        wdtTimeout <= 1'b1;
      else if (haltTaken)
        wdtTimeout <= 1'b0;
    end
  end

  // ****************************************************
  // Clock and power outputs
  // ****************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysClkSource   <= `PMW_SRC_HIGH;
      sysClkDivSel   <= 3'h0;
      sysClkRun      <= 1'b0;
      timebaseClkRun <= 1'b0;
      subClkRun      <= 1'b1;
      highOscRun     <= 1'b1;
      cpuHalted      <= 1'b1;
      ioHold         <= 1'b0;
      pcStackReset   <= 1'b0;
      irqService     <= 1'b0;
      wdtResetReq    <= 1'b0;
    end else begin
      subClkRun    <= 1'b1;
      sysClkDivSel <= divSel;
      pcStackReset <= wakeWdt;
      irqService   <= wakeIrq;
      wdtResetReq  <= wdtOverflow && !downState;
      ioHold       <= |(next_state & (ST_SLEEP | ST_IDLE_CLOCK_OFF |
                        ST_IDLE_CLOCK_ON));
      cpuHalted    <= |(next_state & (ST_SLEEP | ST_IDLE_CLOCK_OFF |
                        ST_IDLE_CLOCK_ON)) ||
                      (next_state == ST_START && !next_runOnLow);
      highOscRun   <= |(next_state & (ST_NORMAL | ST_DIV |
                        ST_IDLE_CLOCK_ON | ST_START));
      timebaseClkRun <= !(next_state == ST_SLEEP);
      case (next_state)
        ST_NORMAL: begin
          sysClkSource <= `PMW_SRC_HIGH;
          sysClkRun    <= 1'b1;
        end
        ST_DIV: begin
          sysClkSource <= `PMW_SRC_DIV;
          sysClkRun    <= 1'b1;
        end
        ST_LOW: begin
          sysClkSource <= `PMW_SRC_LOW;
          sysClkRun    <= 1'b1;
        end
        ST_IDLE_CLOCK_ON: begin
          sysClkRun <= 1'b1;
        end
        ST_START: begin
          sysClkSource <= next_runOnLow ? `PMW_SRC_LOW :
                                          `PMW_SRC_HIGH;
          sysClkRun    <= next_runOnLow;
        end
        default: begin
          sysClkRun <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************
  // AHB-Lite register slave
  // ****************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      hrdata      <= 32'h00000000;
      dpWrite     <= 1'b0;
      dpAddr      <= 8'h00;
      divSel      <= 3'h0;
      fastWake    <= 1'b0;
      idleOnHalt  <= 1'b1;
      highSel     <= 1'b1;
      sysIdle     <= 1'b0;
      wdtPeriod   <= `PMW_WDT_RESET;
      portAWakeEn <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      dpWrite   <= apValid && hwrite;
      dpAddr    <= apAddr;
      if (dpWrite) begin
        case (dpAddr)
          `PMW_ADDR_MODE: begin
            divSel     <= hwdata[`PMW_MODE_DIV_HI:`PMW_MODE_DIV_LO];
            fastWake   <= hwdata[`PMW_MODE_FAST];
            idleOnHalt <= hwdata[`PMW_MODE_IDLE];
            highSel    <= hwdata[`PMW_MODE_HIGHSEL];
          end
          `PMW_ADDR_CTRL:   sysIdle     <= hwdata[`PMW_CTRL_SYSIDLE];
          `PMW_ADDR_WDT:    wdtPeriod   <= hwdata[2:0];
          `PMW_ADDR_WAKEEN: portAWakeEn <= hwdata[7:0];
          default: begin
          end
        endcase
      end
      if (apValid && !hwrite) begin
        case (apAddr)
          `PMW_ADDR_MODE:
            hrdata <= {24'h000000, divSel, fastWake, lowReady,
                       highReady, idleOnHalt, highSel};
          `PMW_ADDR_CTRL:
            hrdata <= {24'h000000, sysIdle, 7'h00};
          `PMW_ADDR_WDT:
            hrdata <= {29'h00000000, wdtPeriod};
          `PMW_ADDR_WAKEEN:
            hrdata <= {24'h000000, portAWakeEn};
          `PMW_ADDR_STATUS:
            hrdata <= {17'h00000, state, 6'h00, wdtTimeout,
                       poweredDown};
          default:
            hrdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// file: src/pmw_consts.vh
`ifndef PMW_CONSTS_VH
`define PMW_CONSTS_VH

// Register byte offsets
`define PMW_ADDR_MODE     8'h00
`define PMW_ADDR_CTRL     8'h04
`define PMW_ADDR_WDT      8'h08
`define PMW_ADDR_WAKEEN   8'h0C
`define PMW_ADDR_STATUS   8'h10

// Mode register fields and reset value
`define PMW_MODE_RESET    8'h03
`define PMW_MODE_DIV_HI   7
`define PMW_MODE_DIV_LO   5
`define PMW_MODE_FAST     4
`define PMW_MODE_LOWRDY   3
`define PMW_MODE_HIGHRDY  2
`define PMW_MODE_IDLE     1
`define PMW_MODE_HIGHSEL  0

// Control register field
`define PMW_CTRL_SYSIDLE  7

// Watchdog period field reset value
`define PMW_WDT_RESET     3'h3

// Clock source codes on the system clock mux
`define PMW_SRC_HIGH      2'h0
`define PMW_SRC_DIV       2'h1
`define PMW_SRC_LOW       2'h2

// Start-up counts in clock cycles
`define PMW_SST_EXT_HIGH  8'h80
`define PMW_SST_INT_HIGH  8'h10
`define PMW_SST_EXT_LOW   8'h80
`define PMW_SST_INT_LOW   8'h02

// AHB codes
`define PMW_HTRANS_NONSEQ 2'h2

`endif

// file: dv/pmw_monitor.sv
`timescale 1ns/1ps
`include "pmw_consts.vh"

module pmw_monitor (
  // Clock and reset
  input wire       clk,
  input wire       rst_n,
  // Observed ports
  input wire       haltExec,
  input wire       stackFull,
  input wire [1:0] sysClkSource,
  input wire [2:0] sysClkDivSel,
  input wire       sysClkRun,
  input wire       timebaseClkRun,
  input wire       subClkRun,
  input wire       cpuHalted,
  input wire       ioHold,
  input wire       pcStackReset,
  input wire       irqService,
  input wire       wdtResetReq
);
  // ****
  // Mode and wake checks
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_halt_enter: assert property (
    haltExec && !cpuHalted |=> cpuHalted && ioHold)
    else $error("halt did not stop the cpu");
  chk_sleep_gate: assert property (
    ioHold && !timebaseClkRun |-> !sysClkRun)
    else $error("system clock runs in sleep");
  chk_run_clocks: assert property (
    !cpuHalted |-> sysClkRun && timebaseClkRun)
    else $error("cpu runs without its clocks");
  chk_sub_alive: assert property (subClkRun)
    else $error("sub clock stopped");
  chk_div_range: assert property (
    sysClkSource == `PMW_SRC_DIV |-> sysClkDivSel >= 3'h2)
    else $error("divided source with low divider code");
  chk_hold_halted: assert property (ioHold |-> cpuHalted)
    else $error("pins held while cpu runs");
  chk_wake_reset: assert property (
    pcStackReset |-> $past(ioHold) ##1 !pcStackReset)
    else $error("pc reset outside watchdog wake");
  chk_irq_wake: assert property (
    irqService |-> $past(ioHold) && $past(stackFull) == 1'b0)
    else $error("interrupt serviced without wake or stack room");
  chk_wdt_run: assert property (wdtResetReq |-> !$past(ioHold))
    else $error("watchdog reset request during power down");
endmodule

bind pmw_power_mode_wake pmw_monitor pmw_monitor_inst (
  .clk(clk), .rst_n(rst_n), .haltExec(haltExec), .stackFull(stackFull),
  .sysClkSource(sysClkSource), .sysClkDivSel(sysClkDivSel),
  .sysClkRun(sysClkRun), .timebaseClkRun(timebaseClkRun),
  .subClkRun(subClkRun), .cpuHalted(cpuHalted), .ioHold(ioHold),
  .pcStackReset(pcStackReset), .irqService(irqService),
  .wdtResetReq(wdtResetReq));

// file: dv/tb_top.sv
`timescale 1ns/1ps
`include "pmw_consts.vh"

module tb_top;
  // ****
  // Signals
  // ****
  logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        haltExec = 1'b0, clearWdtExec = 1'b0, stackFull = 1'b0;
  logic        extHighOsc = 1'b0, extLowOsc = 1'b0, subTick = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  irqRequest = '0, irqEnable = '0, portAPins = 8'hFF;
  wire         hreadyout, hresp, sysClkRun, timebaseClkRun, subClkRun;
  wire         highOscRun, cpuHalted, ioHold, pcStackReset, irqService;
  wire         wdtResetReq;
  wire  [31:0] hrdata;
  wire  [1:0]  sysClkSource;
  wire  [2:0]  sysClkDivSel;
  int          num_errors = 0, total_checks = 0, cycles = 0;
  logic        seenPcs = 1'b0, seenIrq = 1'b0, seenWdt = 1'b0;

  pmw_power_mode_wake pmw_power_mode_wake_inst (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .haltExec(haltExec), .clearWdtExec(clearWdtExec),
    .stackFull(stackFull), .irqRequest(irqRequest),
    .irqEnable(irqEnable), .portAPins(portAPins),
    .extHighOsc(extHighOsc), .extLowOsc(extLowOsc), .subTick(subTick),
    .sysClkSource(sysClkSource), .sysClkDivSel(sysClkDivSel),
    .sysClkRun(sysClkRun), .timebaseClkRun(timebaseClkRun),
    .subClkRun(subClkRun), .highOscRun(highOscRun),
    .cpuHalted(cpuHalted), .ioHold(ioHold), .pcStackReset(pcStackReset),
    .irqService(irqService), .wdtResetReq(wdtResetReq));

  always #50 clk = ~clk;

  always @(posedge clk) begin
    seenPcs <= seenPcs | (pcStackReset === 1'b1);
    seenIrq <= seenIrq | (irqService === 1'b1);
    seenWdt <= seenWdt | (wdtResetReq === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      give_verdict();
    end
  end

  // ****
  // Shared tasks
  // ****
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic chkb(input logic s, input logic e);
    chk({31'h0, s}, {31'h0, e});
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= `PMW_HTRANS_NONSEQ;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic flags(input logic [1:0] e);
    logic [31:0] q;
    ahb(1'b0, `PMW_ADDR_STATUS, 32'h0, q);
    chk(q & 32'h3, {30'h0, e});
  endtask

  task automatic wait_state(input logic [6:0] e);
    logic [31:0] q;
    q = '0;
    for (int i = 0; i < 100 && q[14:8] !== e; i++)
      ahb(1'b0, `PMW_ADDR_STATUS, 32'h0, q);
    chk(q & 32'h7F00, {17'h0, e, 8'h00});
  endtask

  task automatic wait_wake();
    for (int i = 0; i < 300 && cpuHalted !== 1'b0; i++) @(negedge clk);
    chkb(cpuHalted, 1'b0);
  endtask

  task automatic pulse(input logic clr);
    @(posedge clk);
    if (clr) clearWdtExec <= 1'b1;
    else haltExec <= 1'b1;
    @(posedge clk);
    clearWdtExec <= 1'b0;
    haltExec <= 1'b0;
    @(negedge clk);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      subTick <= 1'b1;
      @(posedge clk);
      subTick <= 1'b0;
    end
  endtask

  // ****
  // Scenarios
  // ****
  task automatic test_reset();
    wait_state(7'h01);
    rdchk(`PMW_ADDR_MODE, 32'h0F);
    rdchk(`PMW_ADDR_CTRL, 32'h00);
    rdchk(`PMW_ADDR_WDT, 32'h03);
    rdchk(`PMW_ADDR_WAKEEN, 32'h00);
    rdchk(`PMW_ADDR_STATUS, 32'h0100);
    rdchk(8'h20, 32'h00);
    chkb(hresp, 1'b0);
    chkb(hreadyout, 1'b1);
    $display("test_reset done");
  endtask

  task automatic test_modes();
    for (int d = 2; d < 8; d++) begin
      wr(`PMW_ADDR_MODE, (d << 5) | 32'h02);
      wait_state(7'h02);
      chk({30'h0, sysClkSource}, {30'h0, `PMW_SRC_DIV});
      chk({29'h0, sysClkDivSel}, d);
    end
    for (int d = 0; d < 2; d++) begin
      wr(`PMW_ADDR_MODE, (d << 5) | 32'h02);
      wait_state(7'h04);
      chk({30'h0, sysClkSource}, {30'h0, `PMW_SRC_LOW});
      chkb(highOscRun, 1'b0);
    end
    rdchk(`PMW_ADDR_MODE, 32'h2A);
    wr(`PMW_ADDR_MODE, 32'h03);
    wait_state(7'h01);
    rdchk(`PMW_ADDR_MODE, 32'h0F);
    chk({30'h0, sysClkSource}, {30'h0, `PMW_SRC_HIGH});
    $display("test_modes done");
  endtask

  task automatic test_halt();
    for (int m = 0; m < 3; m++) begin
      wr(`PMW_ADDR_MODE, (m > 0) ? 32'h03 : 32'h01);
      wr(`PMW_ADDR_CTRL, (m == 2) ? 32'h80 : 32'h00);
      wr(`PMW_ADDR_WAKEEN, 32'h01);
      pulse(1'b0);
      chkb(ioHold, 1'b1);
      chkb(sysClkRun, m == 2);
      chkb(timebaseClkRun, m > 0);
      chkb(highOscRun, m == 2);
      rdchk(`PMW_ADDR_STATUS, {17'h0, 7'(8 << m), 8'h01});
      portAPins <= 8'hFD;
      repeat (10) @(posedge clk);
      chkb(cpuHalted, 1'b1);
      portAPins <= 8'hFC;
      wait_wake();
      @(posedge clk);
      portAPins <= 8'hFF;
      wait_state(7'h01);
    end
    $display("test_halt done");
  endtask

  task automatic test_irq();
    wr(`PMW_ADDR_MODE, 32'h01);
    irqEnable <= 8'h02;
    irqRequest <= 8'h01;
    seenIrq = 1'b0;
    pulse(1'b0);
    repeat (20) @(posedge clk);
    chkb(cpuHalted, 1'b1);
    irqRequest <= 8'h03;
    wait_wake();
    chkb(seenIrq, 1'b1);
    @(posedge clk);
    irqRequest <= 8'h00;
    stackFull <= 1'b1;
    wait_state(7'h01);
    seenIrq = 1'b0;
    pulse(1'b0);
    @(posedge clk);
    irqRequest <= 8'h02;
    wait_wake();
    repeat (3) @(posedge clk);
    chkb(seenIrq, 1'b0);
    stackFull <= 1'b0;
    irqRequest <= 8'h00;
    $display("test_irq done");
  endtask

  task automatic test_wdt();
    wait_state(7'h01);
    wr(`PMW_ADDR_WDT, 32'h00);
    ticks(100);
    seenPcs = 1'b0;
    pulse(1'b0);
    ticks(255);
    chkb(cpuHalted, 1'b1);
    ticks(1);
    wait_wake();
    chkb(seenPcs, 1'b1);
    flags(2'h3);
    wait_state(7'h01);
    pulse(1'b1);
    flags(2'h2);
    wr(`PMW_ADDR_WDT, 32'h01);
    pulse(1'b1);
    seenWdt = 1'b0;
    ticks(1023);
    chkb(seenWdt, 1'b0);
    ticks(1);
    repeat (3) @(posedge clk);
    chkb(seenWdt, 1'b1);
    $display("test_wdt done");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    test_reset();
    test_modes();
    test_halt();
    test_irq();
    test_wdt();
    give_verdict();
  end
endmodule
